// ===== src/exmon_core.sv
// module: exclusive monitor with data-cache allocation and barrier stall
module exmon_core (
    // clock and reset
    input  wire logic                   CLOCK,
    input  wire logic                   RESETN,
    // instruction issue from the pipeline
    input  wire exmon_pkg::issue_type   ISSUE,
    output logic                        ISSUE_READY,
    // read answers from the memory system
    input  wire exmon_pkg::fill_type    FILL,
    // data-cache allocation
    output exmon_pkg::alloc_type        ALLOC,
    // store toward memory
    output exmon_pkg::write_type        WRITE,
    // exclusive store result
    output logic                        STORE_DONE,
    output logic                        STORE_FAILED,
    // monitor and barrier stall state
    output logic                        MONITOR_SET,
    output logic                        STALLED
);
    import exmon_pkg::*;

    // -------------------------------------------------------------------
    // request decode
    // -------------------------------------------------------------------
    logic is_load;
    logic is_load_exclusive;
    logic is_store_exclusive;
    logic is_barrier;

    always_comb begin
        is_load            = 1'b0;
        is_load_exclusive  = 1'b0;
        is_store_exclusive = 1'b0;
        is_barrier         = 1'b0;
        // the op field means nothing without valid
        if (ISSUE.valid) begin
            unique case (ISSUE.op)
                OP_PLAIN_LOAD: begin
                    is_load = 1'b1;
                end
                OP_LOAD_EXCLUSIVE: begin
                    is_load           = 1'b1;
                    is_load_exclusive = 1'b1;
                end
                OP_STORE_EXCLUSIVE: begin
                    is_store_exclusive = 1'b1;
                end
                OP_DATA_SYNC_BARRIER: begin
                    is_barrier = 1'b1;
                end
            endcase
        end
    end

    // -------------------------------------------------------------------
    // outstanding load tracking
    // -------------------------------------------------------------------
    logic [OUT_W-1:0] outstanding;
    logic             load_issue;
    logic             load_full;
    logic             barrier_wait;
    logic             accept;

    // loads issued speculatively count too: the barrier waits for them
    assign load_issue = accept && is_load;

    exmon_counter u_outstanding (
        .clk   (CLOCK),
        .rst_n (RESETN),
        .inc   (load_issue),
        .dec   (FILL.valid),
        .count (outstanding)
    );

    // barrier holds issue while any earlier load is in flight
    assign barrier_wait = is_barrier && outstanding != '0;
    // a full tracker holds loads back so the count cannot wrap; an answer
    // in the same cycle frees a place
    assign load_full    = is_load && outstanding == OUT_MAX && !FILL.valid;
    assign accept       = ISSUE.valid && !barrier_wait && !load_full;

    // -------------------------------------------------------------------
    // exclusive monitor
    // -------------------------------------------------------------------
    logic monitor_reg;
    logic monitor_next;
    logic take_load_exclusive;
    logic take_store_exclusive;

    // only a taken request may touch the monitor
    assign take_load_exclusive  = accept && is_load_exclusive;
    assign take_store_exclusive = accept && is_store_exclusive;

    always_comb begin
        monitor_next = monitor_reg;
        // any allocation, valid or invalid, drops the reservation; this is
        // what lets an aborting speculative load starve the pair
        if (FILL.valid) begin
            monitor_next = 1'b0;
        end
        // the store spends the reservation whether it passes or fails
        if (take_store_exclusive) begin
            monitor_next = 1'b0;
        end
        // arming wins over a same-cycle allocation clear
        if (take_load_exclusive) begin
            monitor_next = 1'b1;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RESETN) begin
            monitor_reg <= 1'b0;
        end else begin
            monitor_reg <= monitor_next;
        end
    end

    // -------------------------------------------------------------------
    // data-cache allocation
    // -------------------------------------------------------------------
    alloc_type alloc_reg;
    alloc_type alloc_next;

    always_comb begin
        alloc_next = '0;
        // every answer allocates; an aborted one only as invalid, so a
        // reissued aborting load never leaves a valid line
        if (FILL.valid) begin
            alloc_next.valid      = 1'b1;
            alloc_next.line_valid = !FILL.abort;
            alloc_next.tag        = FILL.addr[ADDR_W-1:TAG_LSB];
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RESETN) begin
            alloc_reg <= '0;
        end else begin
            alloc_reg <= alloc_next;
        end
    end

    // -------------------------------------------------------------------
    // exclusive store result
    // -------------------------------------------------------------------
    write_type write_reg;
    write_type write_next;
    logic      done_reg;
    logic      done_next;
    logic      failed_reg;
    logic      failed_next;

    always_comb begin
        write_next  = '0;
        done_next   = 1'b0;
        failed_next = 1'b0;
        // one pulse per taken store, with or without a write
        if (take_store_exclusive) begin
            done_next = 1'b1;
            // store uses the monitor as it stood, so an allocation in this
            // very cycle does not kill it
            if (monitor_reg) begin
                write_next.valid = 1'b1;
                write_next.addr  = ISSUE.addr;
                write_next.data  = ISSUE.wdata;
            end else begin
                // memory stays untouched; only the flag reports it
                failed_next = 1'b1;
            end
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RESETN) begin
            write_reg  <= '0;
            done_reg   <= 1'b0;
            failed_reg <= 1'b0;
        end else begin
            write_reg  <= write_next;
            done_reg   <= done_next;
            failed_reg <= failed_next;
        end
    end

    // -------------------------------------------------------------------
    // issue status
    // -------------------------------------------------------------------
    logic ready_reg;
    logic ready_next;
    logic stalled_reg;
    logic stalled_next;

    always_comb begin
        // both report the cycle before, since outputs leave from flops;
        // acceptance itself is decided without that delay
        ready_next   = !barrier_wait;
        stalled_next = barrier_wait;
    end

    always_ff @(posedge CLOCK) begin
        if (!RESETN) begin
            ready_reg   <= 1'b0;
            stalled_reg <= 1'b0;
        end else begin
            ready_reg   <= ready_next;
            stalled_reg <= stalled_next;
        end
    end

    // -------------------------------------------------------------------
    // outputs
    // -------------------------------------------------------------------
    assign ALLOC        = alloc_reg;
    assign WRITE        = write_reg;
    assign STORE_DONE   = done_reg;
    assign STORE_FAILED = failed_reg;
    assign MONITOR_SET  = monitor_reg;
    assign ISSUE_READY  = ready_reg;
    assign STALLED      = stalled_reg;
endmodule

// ===== include/exmon_pkg.sv
// package: shared types and constants of the exclusive monitor block
// How it works
// - aborted cacheable read allocates line as invalid
// - any cache allocation clears exclusive monitor, unless an exclusive load is taken that cycle
// - exclusive load sets the monitor
// - exclusive store fails while monitor clear
// - barrier stalls until all loads finish
// - aborted missing load never installs valid
// - mispredicted loop branch may issue following load
package exmon_pkg;
    localparam int ADDR_W  = 32;
    localparam int DATA_W  = 32;
    localparam int TAG_LSB = 5;
    localparam int TAG_W   = ADDR_W - TAG_LSB;
    localparam int OUT_W   = 3;
    localparam logic [OUT_W-1:0] OUT_MAX = 3'h7;
    localparam logic [OUT_W-1:0] OUT_ONE = 3'h1;

    typedef enum logic [1:0] {
        OP_PLAIN_LOAD,
        OP_LOAD_EXCLUSIVE,
        OP_STORE_EXCLUSIVE,
        OP_DATA_SYNC_BARRIER
    } op_type;

    typedef struct packed {
        logic                 valid;
        op_type               op;
        logic                 cacheable;
        logic                 speculative;
        logic [ADDR_W-1:0]    addr;
        logic [DATA_W-1:0]    wdata;
    } issue_type;

    typedef struct packed {
        logic                 valid;
        logic                 abort;
        logic [ADDR_W-1:0]    addr;
    } fill_type;

    typedef struct packed {
        logic                 valid;
        logic                 line_valid;
        logic [TAG_W-1:0]     tag;
    } alloc_type;

    typedef struct packed {
        logic                 valid;
        logic [ADDR_W-1:0]    addr;
        logic [DATA_W-1:0]    data;
    } write_type;
endpackage

// ===== src/exmon_counter.sv
// module: up/down counter of outstanding loads
module exmon_counter (
    // clock and reset
    input  wire logic                       clk,
    input  wire logic                       rst_n,
    // events
    input  wire logic                       inc,
    input  wire logic                       dec,
    // count
    output logic [exmon_pkg::OUT_W-1:0]     count
);
    import exmon_pkg::*;

    logic [OUT_W-1:0] count_reg;
    logic [OUT_W-1:0] count_next;

    always_comb begin
        count_next = count_reg;
        if (inc && !dec) begin
            count_next = count_reg + OUT_ONE;
        end else if (dec && !inc) begin
            count_next = count_reg - OUT_ONE;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            count_reg <= '0;
        end else begin
            count_reg <= count_next;
        end
    end

    assign count = count_reg;
endmodule

// ===== dv/exmon_core_assertions.sv
// checker: port-level properties of the exclusive monitor
module exmon_core_assertions (
    // clock and reset
    input wire logic                 CLOCK,
    input wire logic                 RESETN,
    // observed ports
    input wire exmon_pkg::issue_type ISSUE,
    input wire exmon_pkg::fill_type  FILL,
    input wire exmon_pkg::alloc_type ALLOC,
    input wire exmon_pkg::write_type WRITE,
    input wire logic                 STORE_DONE,
    input wire logic                 STORE_FAILED,
    input wire logic                 MONITOR_SET,
    input wire logic                 STALLED
);
    timeunit 1ns;
    timeprecision 1ps;
    import exmon_pkg::*;
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RESETN);
    // ----------------------------------------
    // outstanding loads as the ports show them
    // ----------------------------------------
    logic [2:0] pend_reg;
    logic [2:0] pend_next;
    logic       ld_take;
    logic       bar;
    assign bar = ISSUE.valid && ISSUE.op == OP_DATA_SYNC_BARRIER;
    assign ld_take = ISSUE.valid && ISSUE.op inside {OP_PLAIN_LOAD, OP_LOAD_EXCLUSIVE}
                     && !(pend_reg == 3'h7 && !FILL.valid);
    always_comb pend_next = pend_reg + 3'(ld_take) - 3'(FILL.valid);
    always_ff @(posedge CLOCK) pend_reg <= RESETN ? pend_next : 3'h0;
    sequence ldex_s; ISSUE.valid && ISSUE.op == OP_LOAD_EXCLUSIVE; endsequence
    sequence stex_s; ISSUE.valid && ISSUE.op == OP_STORE_EXCLUSIVE; endsequence
    // ----------------------------------------
    // properties
    // ----------------------------------------
    pair_success_a: assert property (ldex_s ##1 stex_s |=> STORE_DONE && !STORE_FAILED
        && WRITE.valid) else $error("undisturbed pair failed");
    ldex_arms_a: assert property (ld_take && ISSUE.op == OP_LOAD_EXCLUSIVE |=> MONITOR_SET)
        else $error("monitor not set");
    stex_fails_a: assert property (stex_s ##0 !MONITOR_SET |=> STORE_DONE && STORE_FAILED
        && !WRITE.valid) else $error("store passed on clear monitor");
    alloc_tag_a: assert property (FILL.valid |=> ALLOC.valid
        && ALLOC.tag == $past(FILL.addr[ADDR_W-1:TAG_LSB])) else $error("no allocation");
    abort_invalid_a: assert property (FILL.valid && FILL.abort |=> !ALLOC.line_valid)
        else $error("aborted line valid");
    alloc_clears_a: assert property (FILL.valid && !(ISSUE.valid
        && ISSUE.op == OP_LOAD_EXCLUSIVE) |=> !MONITOR_SET) else $error("monitor kept");
    barrier_waits_a: assert property (bar && pend_reg != 3'h0 |=> STALLED)
        else $error("barrier not stalled");
    barrier_goes_a: assert property (bar && pend_reg == 3'h0 |=> !STALLED)
        else $error("barrier stalled idle");
endmodule

// ===== dv/exmon_memory_model.sv
// model: memory system answering loads, with aborts on command
module exmon_memory_model (
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    input  wire exmon_pkg::issue_type issue,
    input  wire logic                 abort_mode,
    input  wire logic [1:0]           delay,
    output exmon_pkg::fill_type       fill,
    output logic [2:0]                pending
);
    timeunit 1ns;
    timeprecision 1ps;
    import exmon_pkg::*;
    logic [ADDR_W-1:0] q[$];
    int                wait_n = 0;
    int                depth = 0;
    initial fill = '0;
    // idle answer bus keeps toggling so stale values never look valid
    always @(posedge clk) begin
        fill <= '{1'b0, ~fill.abort, ~fill.addr};
        if (!rst_n) begin
            q.delete();
            wait_n = 0;
        end else begin
            if (issue.valid && issue.op inside {OP_PLAIN_LOAD, OP_LOAD_EXCLUSIVE}
                && !(pending == 3'h7 && !fill.valid))
                q.push_back(issue.addr);
            if (q.size() > 0 && wait_n >= delay) begin
                fill <= '{1'b1, abort_mode, q.pop_front()};
                wait_n = 0;
            end else if (q.size() > 0)
                wait_n++;
        end
        depth = q.size();
    end
    assign pending = 3'(depth) + 3'(fill.valid);
endmodule

// ===== dv/exclusive_monitor_abort_alloc_bench.sv
// bench: exclusive monitor scenarios against the memory model
module exclusive_monitor_abort_alloc_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import exmon_pkg::*;
    logic clock = 1'b0, resetn = 1'b0, abort_mode = 1'b0, done, failed, mon, stalled, ready;
    logic [1:0] delay = 2'h1;
    logic [2:0] pending;
    issue_type  issue = '0;
    fill_type   fill;
    write_type  wr;
    alloc_type  alloc;
    logic       exp_q[$];
    int         n_fail = 0, compares = 0, seed = 32'h6a50585d;
    always #2 clock = ~clock;
    exmon_core exmon_core_inst (.CLOCK(clock), .RESETN(resetn), .ISSUE(issue),
        .ISSUE_READY(ready), .FILL(fill), .ALLOC(alloc), .WRITE(wr), .STORE_DONE(done),
        .STORE_FAILED(failed),
        .MONITOR_SET(mon), .STALLED(stalled));
    exmon_memory_model exmon_memory_model_inst (.clk(clock), .rst_n(resetn), .issue(issue),
        .abort_mode(abort_mode), .delay(delay), .fill(fill), .pending(pending));
    task automatic check(string what, logic exp, logic got);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic conclude();
        if (n_fail == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // request stays up after its taking edge; caller releases or replaces it
    task automatic send(op_type op, logic spec, logic exp);
        logic [31:0] a;
        a = $random(seed);
        issue <= '{1'b1, op, 1'b1, spec, a, a};
        if (op == OP_STORE_EXCLUSIVE) exp_q.push_back(exp);
        if (op == OP_DATA_SYNC_BARRIER && pending != 3'h0) begin
            @(negedge clock);
            check("stalled", 1'b1, stalled);
            check("issue_ready", 1'b0, ready);
        end
        while (op == OP_DATA_SYNC_BARRIER && pending != 3'h0) @(negedge clock);
        @(negedge clock);
        check("issue_ready", 1'b1, ready);
        if (op == OP_LOAD_EXCLUSIVE) check("monitor_set", 1'b1, mon);
    endtask
    task automatic idle(int n);
        issue.valid <= 1'b0;
        repeat (n) @(negedge clock);
    endtask
    always @(negedge clock) if (resetn && done === 1'b1) begin
        check("store_failed", exp_q[0], failed);
        check("write_valid", !exp_q.pop_front(), wr.valid);
    end
    // all answers of one pass share its abort setting: the barrier drains them
    always @(negedge clock) if (resetn && alloc.valid === 1'b1) begin
        check("alloc_line_valid", !abort_mode, alloc.line_valid);
    end
    initial begin
        #20000;
        n_fail++;
        conclude();
    end
    initial begin
        repeat (4) @(negedge clock);
        resetn <= 1'b1;
        @(negedge clock);
        send(OP_LOAD_EXCLUSIVE, 1'b0, 1'b0);
        send(OP_STORE_EXCLUSIVE, 1'b0, 1'b0);
        for (int i = 0; i < 8; i++) begin
            abort_mode <= i[0];
            delay <= 2'($random(seed));
            send(OP_LOAD_EXCLUSIVE, 1'b0, 1'b0);
            idle(5);
            send(OP_STORE_EXCLUSIVE, 1'b0, 1'b1);
            // speculative load ahead of the pair, barrier in the middle
            send(OP_PLAIN_LOAD, 1'b1, 1'b0);
            send(OP_LOAD_EXCLUSIVE, 1'b0, 1'b0);
            send(OP_DATA_SYNC_BARRIER, 1'b0, 1'b0);
            send(OP_STORE_EXCLUSIVE, 1'b0, 1'b1);
            idle(5);
        end
        conclude();
    end
endmodule
bind exmon_core exmon_core_assertions exmon_core_assertions_inst (.CLOCK, .RESETN, .ISSUE,
    .FILL, .ALLOC, .WRITE, .STORE_DONE, .STORE_FAILED, .MONITOR_SET, .STALLED);
